// File: hdl/brlog_pkg.sv
// Constants for the bit rate and error event logic
package brlog_pkg;
   // Bus
   localparam int APB_AW = 16;
   localparam logic [15:0] OFF_CTRL = 16'h0000;
   localparam logic [15:0] OFF_CMD = 16'h0004;
   localparam logic [15:0] OFF_STAT = 16'h0008;
   localparam logic [15:0] OFF_EVENT = 16'h3000;
   // Control register fields
   localparam int CTL_RATE_LSB = 0;
   localparam int CTL_MODE = 4;
   localparam int CTL_PAT_A = 5;
   localparam int CTL_PAT_B = 6;
   localparam int CTL_EXT_CLK = 7;
   localparam int CTL_INTL = 8;
   localparam int CTL_CANNED = 9;
   localparam int CTL_DTYPE_LSB = 10;
   localparam int CTL_CBITS_LSB = 12;
   localparam int CTL_W = 14;
   localparam logic [13:0] CTL_RST = 14'h0000;
   // Command register fields
   localparam int CMD_BUF_RST = 0;
   localparam int CMD_SYNC_RST = 1;
   localparam int CMD_START = 2;
   // Status register fields
   localparam int ST_DROP = 0;
   localparam int ST_SYNC = 1;
   localparam int ST_LOL = 2;
   localparam int ST_RATE_OK = 3;
   // Timing
   localparam int PCLK_HZ = 40_000_000;
   localparam int PCLK_MHZ = 40;
   localparam int CLR_PULSE_NS = 1000;
   localparam int CLR_PULSE_CYC = CLR_PULSE_NS * PCLK_MHZ / 1000;
   localparam int DROP_ELEMS = 16;
   // Block lengths in received bits
   localparam logic [10:0] BLK_DOMESTIC = 11'h3E8;
   localparam logic [10:0] BLK_511 = 11'h1FF;
   localparam logic [10:0] BLK_2047 = 11'h7FF;
   localparam logic [1:0] PAT_511 = 2'h1;
   // Divisors of the reference oscillator giving 16x the bit rate
   function automatic logic [10:0] rate_div(input logic mode,
                                            input logic [3:0] code);
      logic [10:0] d;
      d = 11'h000;
      if (!mode) begin
         case (code)
            4'h0: d = 11'h600;
            4'h1: d = 11'h417;
            4'h2: d = 11'h359;
            4'h3: d = 11'h300;
            4'h4: d = 11'h240;
            4'h5: d = 11'h180;
            4'h6: d = 11'h0C0;
            4'h7: d = 11'h060;
            4'h8: d = 11'h040;
            4'h9: d = 11'h030;
            4'hA: d = 11'h020;
            4'hB: d = 11'h018;
            4'hC: d = 11'h010;
            4'hD: d = 11'h00C;
            default: d = 11'h000;
         endcase
      end else begin
         case (code)
            4'hA: d = 11'h008;
            4'hB: d = 11'h006;
            default: d = 11'h000;
         endcase
      end
      return d;
   endfunction
endpackage

// File: hdl/brlog_core.sv
// Bit rate clocks, event counters and APB register slave
`timescale 1ns/1ps
`default_nettype none
module brlog_core
   import brlog_pkg::*;
#(
   parameter int SEC_CYCLES = PCLK_HZ,
   parameter int CNT_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_osc,
   input wire logic ext_tx_clk,
   input wire logic rx_bit_clk,
   input wire logic rx_data,
   input wire logic bit_error,
   input wire logic sync_detect,
   input wire logic clock_slip,
   input wire logic loss_of_lock,
   input wire logic ale,
   input wire logic [2:0] port2_low,
   input wire logic [7:0] t1_sources,
   output logic clk_x16,
   output logic bit_clk_x1,
   output logic bit_clk_x2,
   output logic tx_clk,
   output logic rate_code_bit_0,
   output logic rate_code_bit_1,
   output logic rate_code_bit_2,
   output logic rate_code_bit_3,
   output logic high_rate_mode_bit,
   output logic pattern_select_a_out,
   output logic pattern_select_b_out,
   output logic [1:0] data_type,
   output logic [1:0] char_bits,
   output logic rx_resync,
   output logic drop_out,
   output logic sync_status,
   output logic timer_zero_pin,
   output logic timer_one_input,
   output logic int_n
);

   localparam int PW = 20;

   // Pin synchronisers: a bit changes once stages two and three agree
   logic [PW-1:0] pin_raw;
   logic [PW-1:0] s1_q;
   logic [PW-1:0] s2_q;
   logic [PW-1:0] s3_q;
   logic [PW-1:0] pin_q;
   logic [PW-1:0] pin_prev_q;
   assign pin_raw = {t1_sources, port2_low, ale, clock_slip, loss_of_lock,
                     sync_detect, bit_error, rx_data, rx_bit_clk,
                     ext_tx_clk, ref_osc};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
         pin_prev_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
         pin_prev_q <= pin_q;
      end
   end

   wire ref_rise = pin_q[0] & ~pin_prev_q[0];
   wire ext_clk_f = pin_q[1];
   wire rx_rise = pin_q[2] & ~pin_prev_q[2];
   wire rxd_f = pin_q[3];
   wire err_f = pin_q[4];
   wire sync_f = pin_q[5];
   wire lol_f = pin_q[6];
   wire slip_rise = pin_q[7] & ~pin_prev_q[7];
   wire ale_rise = pin_q[8] & ~pin_prev_q[8];
   wire [2:0] p2_f = pin_q[11:9];
   wire [7:0] t1_f = pin_q[19:12];

   // Register bus
   logic [CTL_W-1:0] ctrl_q;
   logic [31:0] prdata_q;
   wire hit_ctrl = paddr == OFF_CTRL;
   wire hit_cmd = paddr == OFF_CMD;
   wire hit_stat = paddr == OFF_STAT;
   wire hit_event = paddr == OFF_EVENT;
   wire hit_any = hit_ctrl | hit_cmd | hit_stat | hit_event;
   wire acc = psel & penable;
   wire wr = acc & pwrite & hit_any;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire cmd_wr = wr & hit_cmd;
   wire buf_rst = cmd_wr & pwdata[CMD_BUF_RST];
   wire sync_rst = cmd_wr & pwdata[CMD_SYNC_RST];
   wire test_start = cmd_wr & pwdata[CMD_START];

   assign pready = 1'b1;
   assign pslverr = acc & ~hit_any;
   assign prdata = prdata_q;

   // Rate generator
   wire [3:0] rate_code = ctrl_q[CTL_RATE_LSB +: 4];
   wire [10:0] div = rate_div(ctrl_q[CTL_MODE], rate_code);
   wire rate_ok = div != 11'h000;
   logic [10:0] div_cnt_q;
   logic x16_q;
   logic [3:0] cnt16_q;
   logic tx_clk_q;
   wire div_wrap = div_cnt_q >= div - 11'h001;
   wire x16_tick = ref_rise & rate_ok & div_wrap;

   // Single programmable divider stands in for the sixteen taps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= '0;
         x16_q <= 1'b0;
      end else if (ref_rise) begin
         div_cnt_q <= (div_wrap || !rate_ok) ? 11'h000
                      : div_cnt_q + 11'h001;
         x16_q <= rate_ok & (div_cnt_q < (div >> 1));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt16_q <= '0;
         tx_clk_q <= 1'b0;
      end else begin
         if (x16_tick)
            cnt16_q <= cnt16_q + 4'h1;
         tx_clk_q <= ctrl_q[CTL_EXT_CLK] ? ext_clk_f : cnt16_q[3];
      end
   end

   assign clk_x16 = x16_q;
   assign bit_clk_x1 = cnt16_q[3];
   assign bit_clk_x2 = cnt16_q[2];
   assign tx_clk = tx_clk_q;

   // Expander-style outputs steered by the control register
   assign rate_code_bit_0 = ctrl_q[CTL_RATE_LSB];
   assign rate_code_bit_1 = ctrl_q[CTL_RATE_LSB+1];
   assign rate_code_bit_2 = ctrl_q[CTL_RATE_LSB+2];
   assign rate_code_bit_3 = ctrl_q[CTL_RATE_LSB+3];
   assign high_rate_mode_bit = ctrl_q[CTL_MODE];
   assign pattern_select_a_out = ctrl_q[CTL_PAT_A];
   assign pattern_select_b_out = ctrl_q[CTL_PAT_B];
   assign data_type = ctrl_q[CTL_DTYPE_LSB +: 2];
   assign char_bits = ctrl_q[CTL_CBITS_LSB +: 2];

   // One-second timer and clear pulse
   logic [31:0] sec_cnt_q;
   logic [7:0] clr_cnt_q;
   wire sec_tick = sec_cnt_q == 32'(SEC_CYCLES - 1);
   wire clr_active = clr_cnt_q != 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_q <= '0;
         clr_cnt_q <= '0;
      end else begin
         sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
         if (sec_tick)
            clr_cnt_q <= 8'(CLR_PULSE_CYC);
         else if (clr_active)
            clr_cnt_q <= clr_cnt_q - 8'h01;
      end
   end

   // Block length selection
   wire [1:0] pat = {ctrl_q[CTL_PAT_A], ctrl_q[CTL_PAT_B]};
   wire [10:0] blk_len = !ctrl_q[CTL_INTL] ? BLK_DOMESTIC
                         : (pat == PAT_511) ? BLK_511 : BLK_2047;
   logic [10:0] bit_cnt_q;
   wire blk_end = rx_rise & (bit_cnt_q >= blk_len - 11'h001);
   wire rx_err = rx_rise & err_f;

   // Event counters
   logic [CNT_W-1:0] blk_cnt_q;
   logic [CNT_W-1:0] berr_cnt_q;
   logic [CNT_W-1:0] es_cnt_q;
   logic blk_err_flag_q;
   logic es_flag_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_q <= '0;
         blk_cnt_q <= '0;
         berr_cnt_q <= '0;
         blk_err_flag_q <= 1'b0;
      end else if (buf_rst) begin
         bit_cnt_q <= '0;
         blk_cnt_q <= '0;
         berr_cnt_q <= '0;
         blk_err_flag_q <= 1'b0;
      end else if (rx_rise) begin
         bit_cnt_q <= blk_end ? 11'h000 : bit_cnt_q + 11'h001;
         if (blk_end) begin
            blk_cnt_q <= blk_cnt_q + CNT_W'(1);
            if (blk_err_flag_q || err_f)
               berr_cnt_q <= berr_cnt_q + CNT_W'(1);
            blk_err_flag_q <= 1'b0;
         end else if (err_f) begin
            blk_err_flag_q <= 1'b1;
         end
      end
   end

   // Error seconds: an error on the tick closes out the ending second,
   // so the clear window after it cannot swallow a fresh error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         es_cnt_q <= '0;
         es_flag_q <= 1'b0;
      end else if (buf_rst) begin
         es_cnt_q <= '0;
         es_flag_q <= 1'b0;
      end else begin
         if (sec_tick && (es_flag_q || rx_err))
            es_cnt_q <= es_cnt_q + CNT_W'(1);
         if (sec_tick)
            es_flag_q <= 1'b0;
         else if (rx_err)
            es_flag_q <= 1'b1;
      end
   end

   // Drop out and sync latches
   logic [4:0] quiet_q;
   logic last_rxd_q;
   logic drop_q;
   logic sync_q;
   logic resync_q;
   wire quiet_over = rx_rise & (rxd_f == last_rxd_q)
                     & (quiet_q == 5'(DROP_ELEMS));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_q <= '0;
         last_rxd_q <= 1'b0;
      end else if (rx_rise) begin
         last_rxd_q <= rxd_f;
         if (rxd_f != last_rxd_q)
            quiet_q <= '0;
         else if (quiet_q <= 5'(DROP_ELEMS))
            quiet_q <= quiet_q + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_q <= 1'b0;
         sync_q <= 1'b0;
         resync_q <= 1'b0;
      end else begin
         if (quiet_over)
            drop_q <= 1'b1;
         else if (sync_rst)
            drop_q <= 1'b0;
         if (sync_f)
            sync_q <= 1'b1;
         else if (sync_rst)
            sync_q <= 1'b0;
         resync_q <= test_start | quiet_over | slip_rise;
      end
   end

   assign drop_out = drop_q;
   assign sync_status = sync_q;
   assign rx_resync = resync_q;

   // Dedicated controller inputs
   logic [1:0] div4_q;
   logic [2:0] t1_sel_q;
   logic t0_q;
   logic t1_q;
   logic int_n_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div4_q <= '0;
         t1_sel_q <= '0;
         t0_q <= 1'b0;
         t1_q <= 1'b0;
         int_n_q <= 1'b1;
      end else begin
         div4_q <= div4_q + 2'h1;
         if (ale_rise)
            t1_sel_q <= p2_f;
         t0_q <= ctrl_q[CTL_CANNED] ? div4_q[1] : lol_f;
         t1_q <= t1_f[t1_sel_q];
         int_n_q <= ~(sec_tick | clr_active);
      end
   end

   assign timer_zero_pin = t0_q;
   assign timer_one_input = t1_q;
   assign int_n = int_n_q;

   // Read path: data captured in setup, valid through access
   wire [7:0] event_byte = {es_cnt_q[1:0], blk_cnt_q[2:0],
                            berr_cnt_q[2:0]};
   wire [31:0] stat_word = {28'h000_0000, rate_ok, lol_f, sync_q, drop_q};
   wire [31:0] rd_mux = hit_ctrl ? {18'h0_0000, ctrl_q}
                        : hit_stat ? stat_word
                        : hit_event ? {24'h00_0000, event_byte}
                        : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTL_RST;
         prdata_q <= '0;
      end else begin
         if (wr && hit_ctrl)
            ctrl_q <= pwdata[CTL_W-1:0];
         if (setup_rd)
            prdata_q <= rd_mux;
      end
   end

endmodule // brlog_core
`default_nettype wire

// File: testbench/brlog_sva.sv
// Port assertions for the rate and event logic
`timescale 1ns/1ps
`default_nettype none
module brlog_sva
   import brlog_pkg::*;
#(
   parameter int SEC_CYCLES = PCLK_HZ,
   parameter int CNT_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic clock_slip,
   input wire logic clk_x16,
   input wire logic bit_clk_x1,
   input wire logic bit_clk_x2,
   input wire logic rate_code_bit_0,
   input wire logic rate_code_bit_1,
   input wire logic rate_code_bit_2,
   input wire logic rate_code_bit_3,
   input wire logic high_rate_mode_bit,
   input wire logic pattern_select_a_out,
   input wire logic pattern_select_b_out,
   input wire logic [1:0] data_type,
   input wire logic [1:0] char_bits,
   input wire logic rx_resync,
   input wire logic drop_out,
   input wire logic int_n
);
   logic [31:0] lo_q;
   logic [31:0] sec_q;
   logic seen_q;
   wire acc = psel && penable;
   wire wr_ctl = acc && pwrite && paddr == OFF_CTRL;
   wire mapped = paddr inside {OFF_CTRL, OFF_CMD, OFF_STAT, OFF_EVENT};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // First tick after reset has no reference, hence seen_q
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_q <= 32'h0000_0000;
         sec_q <= 32'h0000_0000;
         seen_q <= 1'b0;
      end else begin
         lo_q <= int_n ? 32'h0000_0000 : lo_q + 32'h0000_0001;
         sec_q <= $fell(int_n) ? 32'h0000_0001 : sec_q + 32'h0000_0001;
         seen_q <= seen_q || $fell(int_n);
      end
   end
   ready_high_a: assert property (pready)
      else $error("pready low");
   unmapped_err_a: assert property (acc && !mapped |-> pslverr)
      else $error("no error on unmapped access");
   rate_pins_a: assert property (wr_ctl |=>
      {high_rate_mode_bit, rate_code_bit_3, rate_code_bit_2,
       rate_code_bit_1, rate_code_bit_0} == $past(pwdata[4:0]))
      else $error("rate pins wrong");
   pat_pins_a: assert property (wr_ctl |=>
      {pattern_select_b_out, pattern_select_a_out} == $past(pwdata[6:5]))
      else $error("pattern pins wrong");
   latch_pins_a: assert property (wr_ctl |=>
      {char_bits, data_type} == $past(pwdata[13:10]))
      else $error("type pins wrong");
   x2_with_x1_a: assert property ($changed(bit_clk_x1) |->
      $changed(bit_clk_x2))
      else $error("x1 moved without x2");
   resync_drop_a: assert property ($rose(drop_out) |-> rx_resync)
      else $error("no resync after drop out");
   resync_slip_a: assert property ($rose(clock_slip) |->
      ##[4:6] rx_resync)
      else $error("no resync after clock slip");
   x16_low_a: assert property ($changed(bit_clk_x1) |-> !clk_x16)
      else $error("x1 moved while x16 high");
   int_width_a: assert property ($rose(int_n) |->
      lo_q == CLR_PULSE_CYC + 1)
      else $error("second pulse width wrong");
   sec_period_a: assert property ($fell(int_n) && seen_q |->
      sec_q == SEC_CYCLES)
      else $error("second period wrong");
   cover property ($rose(drop_out));
   cover property ($fell(int_n));
   cover property (acc && pslverr);
   cover property ($rose(rx_resync));
endmodule // brlog_sva
bind brlog_core brlog_sva #(.SEC_CYCLES(SEC_CYCLES), .CNT_W(CNT_W)) u_sva (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .clock_slip, .clk_x16, .bit_clk_x1, .bit_clk_x2,
   .rate_code_bit_0, .rate_code_bit_1,
   .rate_code_bit_2, .rate_code_bit_3, .high_rate_mode_bit,
   .pattern_select_a_out, .pattern_select_b_out, .data_type, .char_bits,
   .rx_resync, .drop_out, .int_n);
`default_nettype wire

// File: testbench/brlog_rx_src.sv
// Received line source: bit clock, data and error flag
`timescale 1ns/1ps
`default_nettype none
module brlog_rx_src (
   input wire logic pclk,
   output logic rx_bit_clk,
   output logic rx_data,
   output logic bit_error
);
   initial begin
      rx_bit_clk = 1'b0;
      rx_data = 1'b0;
      bit_error = 1'b1;
   end
   // Clock stands low between frames; error flag idles inverted
   task automatic send(input int n, input logic hold, input int e1,
                       input int e2);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         rx_bit_clk <= 1'b0;
         rx_data <= hold ? rx_data : ~rx_data;
         bit_error <= i == e1 || i == e2;
         repeat (4) @(posedge pclk);
         rx_bit_clk <= 1'b1;
         repeat (3) @(posedge pclk);
      end
      @(posedge pclk);
      rx_bit_clk <= 1'b0;
      bit_error <= ~bit_error;
   endtask
endmodule // brlog_rx_src
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the rate and event logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import brlog_pkg::*;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic ref_osc, ext_tx_clk = 1'b0, clock_slip = 1'b0, ale = 1'b0;
   logic sync_detect = 1'b0, loss_of_lock = 1'b0;
   logic [2:0] port2_low = 3'h0;
   logic [7:0] t1_sources = 8'h00;
   logic pready, rx_bit_clk, rx_data, bit_error, bit_clk_x1;
   logic timer_zero_pin, timer_one_input, int_n, tx_clk, sync_status;
   logic [31:0] expq[$];
   int n_mismatch, comparisons;
   brlog_core #(.SEC_CYCLES(200)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(), .ref_osc,
      .ext_tx_clk, .rx_bit_clk, .rx_data, .bit_error, .sync_detect,
      .clock_slip, .loss_of_lock, .ale, .port2_low, .t1_sources,
      .clk_x16(), .bit_clk_x1, .bit_clk_x2(), .tx_clk, .rate_code_bit_0(),
      .rate_code_bit_1(), .rate_code_bit_2(), .rate_code_bit_3(),
      .high_rate_mode_bit(), .pattern_select_a_out(),
      .pattern_select_b_out(), .data_type(), .char_bits(), .rx_resync(),
      .drop_out(), .sync_status, .timer_zero_pin, .timer_one_input,
      .int_n);
   brlog_rx_src src (.pclk, .rx_bit_clk, .rx_data, .bit_error);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      ref_osc = 1'b0;
      forever #271.2674 ref_osc = ~ref_osc;
   end
   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         n_mismatch++;
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0)
         chk(expq.pop_front(), prdata);
   end
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Pins pass a three-stage synchroniser, so let them settle first
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      repeat (6) @(posedge pclk);
      expq.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic rise(output realtime t);
      int k;
      k = 0;
      while (bit_clk_x1 !== 1'b0 && k < 9000) begin
         @(negedge pclk);
         k++;
      end
      while (bit_clk_x1 !== 1'b1 && k < 9000) begin
         @(negedge pclk);
         k++;
      end
      if (k >= 9000) begin
         n_mismatch++;
         close_out();
      end
      t = $realtime;
   endtask
   initial begin
      realtime t0, t1;
      real hz[2] = '{9600.0, 19200.0};
      logic [31:0] code[2] = '{32'h0000_000D, 32'h0000_001B};
      logic [2:0] s;
      logic [7:0] v;
      logic ok;
      int ones;
      void'($urandom(42470));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'h0000_0001, 32'(int_n));
      rd(OFF_CTRL, 32'h0000_0000);
      rd(OFF_EVENT, 32'h0000_0000);
      $display("Test reset done");
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 16; c++) begin
            apb(1'b1, OFF_CTRL, 32'(m * 16 + c));
            ok = m ? (c == 10 || c == 11) : (c < 14);
            rd(OFF_STAT, {28'h000_0000, ok, 3'b000});
         end
      end
      // Edges are quantised to pclk, so allow 60 ns of slack, 2.4 periods
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, OFF_CTRL, code[i]);
         rise(t0);
         rise(t0);
         rise(t1);
         ok = (t1 - t0) < 1.0e9 / hz[i] + 60.0;
         chk(32'h0000_0001, 32'(ok && (t1 - t0) > 1.0e9 / hz[i] - 60.0));
         // Internal source: tx clock trails the x1 clock by one register
         @(negedge pclk);
         chk(32'h0000_0001, 32'(tx_clk));
      end
      apb(1'b1, 16'h0010, 32'h0000_3FFF);
      rd(16'h0010, 32'h0000_0000);
      rd(OFF_CTRL, 32'h0000_001B);
      apb(1'b1, OFF_CTRL, 32'hFFFF_FFFF);
      rd(OFF_CTRL, 32'h0000_3FFF);
      chk(32'h0000_0000, 32'(tx_clk));
      ext_tx_clk <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'h0000_0001, 32'(tx_clk));
      $display("Test rate done");
      apb(1'b1, OFF_CTRL, 32'h0000_0000);
      apb(1'b1, OFF_CMD, 32'h0000_0005);
      src.send(999, 1'b0, 10, 900);
      rd(OFF_EVENT, 32'h0000_0080);
      src.send(1, 1'b0, -1, -1);
      rd(OFF_EVENT, 32'h0000_0089);
      rd(OFF_CMD, 32'h0000_0000);
      apb(1'b1, OFF_CMD, 32'h0000_0001);
      rd(OFF_EVENT, 32'h0000_0000);
      apb(1'b1, OFF_CTRL, 32'h0000_0100 | (32'(PAT_511[1]) << CTL_PAT_A)
          | (32'(PAT_511[0]) << CTL_PAT_B));
      src.send(510, 1'b0, -1, -1);
      rd(OFF_EVENT, 32'h0000_0000);
      src.send(1, 1'b0, -1, -1);
      rd(OFF_EVENT, 32'h0000_0008);
      $display("Test block done");
      src.send(16, 1'b1, -1, -1);
      rd(OFF_STAT, 32'h0000_0008);
      src.send(1, 1'b1, -1, -1);
      rd(OFF_STAT, 32'h0000_0009);
      sync_detect <= 1'b1;
      clock_slip <= 1'b1;
      repeat (8) @(posedge pclk);
      sync_detect <= 1'b0;
      clock_slip <= 1'b0;
      rd(OFF_STAT, 32'h0000_000B);
      chk(32'h0000_0001, 32'(sync_status));
      apb(1'b1, OFF_CMD, 32'h0000_0002);
      loss_of_lock <= 1'b1;
      rd(OFF_STAT, 32'h0000_000C);
      chk(32'h0000_0001, 32'(timer_zero_pin));
      $display("Test drop done");
      apb(1'b1, OFF_CTRL, 32'h0000_0200);
      // One edge for the pin to leave the lock level
      @(posedge pclk);
      ones = 0;
      repeat (8) begin
         @(negedge pclk);
         ones += timer_zero_pin;
      end
      chk(32'h0000_0004, 32'(ones));
      for (int i = 0; i < 4; i++) begin
         s = 3'($urandom);
         v = 8'($urandom);
         @(posedge pclk);
         port2_low <= s;
         t1_sources <= v;
         ale <= 1'b1;
         repeat (8) @(posedge pclk);
         ale <= 1'b0;
         repeat (8) @(posedge pclk);
         chk(32'(v[s]), 32'(timer_one_input));
      end
      $display("Test timer done");
      close_out();
   end
endmodule // testbench
`default_nettype wire
